/* File: bench/pidp_sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Sensor front end: one settled reading per clock, same domain as the block
module pidp_sensor_model (
  input  wire logic               clk,
  input  wire logic signed [15:0] t1_set,
  input  wire logic signed [15:0] t2_set,
  output logic signed [15:0]      temp1,
  output logic signed [15:0]      temp2
);
  // Registered so a new reading never lands inside the sampling edge
  always @(posedge clk) begin
    temp1 <= t1_set;
    temp2 <= t2_set;
  end
endmodule
`default_nettype wire

/* File: bench/pidp_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module pidp_top_bench import pidp_pkg::*;;
  typedef struct packed {
    pidp_ctype_t        ct;
    logic signed [15:0] tmp;
    logic [15:0]        hm;
    logic [15:0]        cm;
    logic signed [15:0] pw;
  } pidp_row_t;
  localparam int TICK = 200;
  logic               clk = 1'h0;
  logic               rst;
  logic               rd;
  logic               wr;
  logic               waitreq;
  logic               power_en;
  logic               nv_wr;
  logic [7:0]         addr;
  logic [7:0]         nv_addr;
  logic [15:0]        nv_data;
  logic [31:0]        wdata;
  logic [31:0]        rdata;
  logic [31:0]        got;
  logic signed [15:0] t1_set;
  logic signed [15:0] t2_set;
  logic signed [15:0] temp1;
  logic signed [15:0] temp2;
  logic signed [15:0] power;
  int                 errors = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  logic [7:0]         ra [7] = '{A_CTRL, A_SETPT, A_PBAND, A_IGAIN, A_DBAND, A_COOLM, 8'h40};
  logic [15:0]        rv [7] = '{16'h0000, RST_SETPT, RST_PBAND, 16'h0000, RST_DBAND,
                                 RST_MULT, 16'h0000};
  // Set point 25.00, band 20.00: 1.00 degree of error is 10.00 percent
  pidp_row_t          rows [11] = '{
    '{CT_PID,   16'sh09C4, 16'h0064, 16'h0064, 16'sh0000},
    '{CT_PID,   16'sh0A28, 16'h0064, 16'h0064, 16'sh03E8},
    '{CT_PID,   16'sh0FA0, 16'h0064, 16'h0064, 16'sh2710},
    '{CT_PID,   16'sh0960, 16'h00C8, 16'h0064, 16'shF830},
    '{CT_PID,   16'sh0A28, 16'h0064, 16'h0000, 16'sh0000},
    '{CT_PID,   16'sh0960, 16'h0000, 16'h0064, 16'sh0000},
    '{CT_DBAND, 16'sh0A00, 16'h0064, 16'h0064, 16'sh2710},
    '{CT_DBAND, 16'sh09EC, 16'h0064, 16'h0064, 16'sh0000},
    '{CT_DBAND, 16'sh0988, 16'h0064, 16'h0064, 16'shD8F0},
    '{CT_DIRECT, 16'sh09C4, 16'h0064, 16'h00C8, 16'sh1388},
    '{CT_PID,   16'sh0A00, 16'h0064, 16'h0064, 16'sh0258}};
  ////////////////////////////////////////////////////////////////////////////
  pidp_top #(.TICK_CYC(TICK)) dut (.CLK(clk), .RST(rst), .CE(1'h1),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .TEMP1_IN(temp1), .TEMP2_IN(temp2), .POWER_OUT(power), .POWER_EN(power_en),
    .NV_WR(nv_wr), .NV_ADDR(nv_addr), .NV_DATA(nv_data));
  pidp_sensor_model sensor (.clk(clk), .t1_set(t1_set), .t2_set(t2_set),
    .temp1(temp1), .temp2(temp2));
  ////////////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= {16'h0000, d};
    @(posedge clk);
    while (waitreq !== 1'h0) @(posedge clk);
    got = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  // Margin covers the pass latency of roughly 123 cycles
  task automatic passes(input int n);
    repeat (n * TICK + 150) @(posedge clk);
  endtask
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    rd = 1'h0;
    wr = 1'h0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    t1_set = 16'sh09C4;
    t2_set = 16'sh0000;
    repeat (6) @(posedge clk);
    check({power_en, nv_wr, waitreq, power}, {3'h1, 16'h0000});
    rst <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      bus(1'h0, ra[i], 16'h0000);
      check(got, {16'h0000, rv[i]});
    end
    for (int i = 0; i < 11; i++) begin
      bus(1'h1, A_CTRL, {12'h000, rows[i].ct, 2'h1});
      bus(1'h1, A_HEATM, rows[i].hm);
      bus(1'h1, A_COOLM, rows[i].cm);
      t1_set <= rows[i].tmp;
      passes(2);
      check(power, rows[i].pw);
      bus(1'h0, A_POWER, 16'h0000);
      check(got, {16'h0000, rows[i].pw});
    end
    bus(1'h1, A_SETPT, 16'h0A00);
    passes(2);
    check({power_en, power}, 17'h10000);
    bus(1'h0, A_STAT, 16'h0000);
    check(got[2:1], 2'h1);
    bus(1'h1, A_CTRL, 16'h0003);
    bus(1'h1, A_SETPT, 16'h09C4);
    #1;
    check({nv_wr, nv_addr, nv_data}, {1'h1, A_SETPT, 16'h09C4});
    bus(1'h1, A_CTRL, 16'h0001);
    bus(1'h1, A_SETPT, 16'h09C4);
    #1;
    check(nv_wr, 1'h0);
    // Offsets pull both readings back to set point and to 10.50
    bus(1'h1, A_OFS1, 16'hFFC4);
    bus(1'h1, A_OFS2, 16'h0032);
    t2_set <= 16'sh03E8;
    passes(2);
    check(power, 16'sh0000);
    bus(1'h0, A_TEMP1, 16'h0000);
    check(got[15:0], 16'h09C4);
    bus(1'h0, A_TEMP2, 16'h0000);
    check(got[15:0], 16'h041A);
    bus(1'h1, A_OFS1, 16'h0000);
    bus(1'h1, A_IGAIN, 16'h07D0);
    bus(1'h0, A_IGAIN, 16'h0000);
    check(got, {16'h0000, GAIN_MAX});
    bus(1'h1, A_DGAIN, 16'h07D0);
    bus(1'h0, A_DGAIN, 16'h0000);
    check(got, {16'h0000, GAIN_MAX});
    bus(1'h1, A_DBAND, 16'h0005);
    bus(1'h0, A_DBAND, 16'h0000);
    check(got, {16'h0000, DBAND_MIN});
    // Full derivative gain on a steady error must add nothing
    bus(1'h1, A_IGAIN, 16'h0000);
    passes(3);
    check(power, 16'sh0258);
    // Error 4.00 gives 40.00 percent; integral adds under 0.10 in 12 samples
    bus(1'h1, A_DGAIN, 16'h0000);
    bus(1'h1, A_IGAIN, 16'h03E8);
    t1_set <= 16'sh0B54;
    passes(12);
    check((power > 16'sh0FA0) && (power < 16'sh1000), 1'h1);
    bus(1'h1, A_CTRL, 16'h0000);
    passes(2);
    check({power_en, power}, 17'h00000);
    // Reset in mid-run must clear outputs and working memory
    rst <= 1'h1;
    @(posedge clk);
    check({power_en, nv_wr, waitreq, power}, {3'h1, 16'h0000});
    check(rdata, 32'h00000000);
    rst <= 1'h0;
    bus(1'h0, A_IGAIN, 16'h0000);
    check(got, 32'h00000000);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: rtl/pidp_div.sv */
`timescale 1ns/10ps
`default_nettype none
// Restoring divider, one quotient bit per cycle, truncates toward zero
module pidp_div #(
  parameter int WN = 40,
  parameter int WD = 24
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 start,
  input  wire logic signed [WN-1:0] num,
  input  wire logic [WD-1:0]        den,
  output logic                      done,
  output logic signed [WN-1:0]      quo
);
  localparam int CW = $clog2(WN + 1);
  logic [WD:0]   rem_q, rem_d, sh;
  logic [WN-1:0] q_q, q_d;
  logic [WD-1:0] den_q, den_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          neg_q, neg_d, busy_q, busy_d, done_d;
  logic signed [WN-1:0] quo_d;
  always_comb begin
    rem_d  = rem_q;
    q_d    = q_q;
    den_d  = den_q;
    cnt_d  = cnt_q;
    neg_d  = neg_q;
    busy_d = busy_q;
    done_d = 1'b0;
    quo_d  = quo;
    sh     = {rem_q[WD-1:0], q_q[WN-1]};
    if (start) begin
      rem_d  = '0;
      q_d    = num[WN-1] ? WN'(-num) : num;
      den_d  = den;
      neg_d  = num[WN-1];
      cnt_d  = CW'(WN);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (sh >= {1'b0, den_q}) begin
        rem_d = sh - {1'b0, den_q};
        q_d   = {q_q[WN-2:0], 1'b1};
      end else begin
        rem_d = sh;
        q_d   = {q_q[WN-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        quo_d  = neg_q ? WN'(-q_d) : q_d;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_q  <= '0;
      q_q    <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      neg_q  <= 1'b0;
      busy_q <= 1'b0;
      done   <= 1'b0;
      quo    <= '0;
    end else if (ce) begin
      rem_q  <= rem_d;
      q_q    <= q_d;
      den_q  <= den_d;
      cnt_q  <= cnt_d;
      neg_q  <= neg_d;
      busy_q <= busy_d;
      done   <= done_d;
      quo    <= quo_d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pidp_pkg.sv */
package pidp_pkg;
  // Byte offsets of the Avalon-MM register words
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_SETPT = 8'h04;
  localparam logic [7:0] A_PBAND = 8'h08;
  localparam logic [7:0] A_IGAIN = 8'h0C;
  localparam logic [7:0] A_DGAIN = 8'h10;
  localparam logic [7:0] A_DBAND = 8'h14;
  localparam logic [7:0] A_OFS1  = 8'h18;
  localparam logic [7:0] A_OFS2  = 8'h1C;
  localparam logic [7:0] A_HEATM = 8'h20;
  localparam logic [7:0] A_COOLM = 8'h24;
  localparam logic [7:0] A_TEMP1 = 8'h28;
  localparam logic [7:0] A_TEMP2 = 8'h2C;
  localparam logic [7:0] A_POWER = 8'h30;
  localparam logic [7:0] A_STAT  = 8'h34;
  // Control word fields
  localparam int CTRL_OUT_ON  = 0;
  localparam int CTRL_NV_EN   = 1;
  localparam int CTRL_TYPE_LO = 2;
  localparam int CTRL_TYPE_HI = 3;
  typedef enum logic [1:0] {
    CT_PID    = 2'h0,
    CT_DBAND  = 2'h1,
    CT_DIRECT = 2'h2
  } pidp_ctype_t;
  // Limits, hundredths of a unit
  localparam logic [15:0] GAIN_MAX  = 16'h03E8;
  localparam logic [15:0] PBAND_MIN = 16'h0064;
  localparam logic [15:0] PBAND_MAX = 16'h2710;
  localparam logic [15:0] DBAND_MIN = 16'h000A;
  localparam logic [15:0] DBAND_MAX = 16'h2710;
  localparam logic [15:0] MULT_MAX  = 16'h00C8;
  // Reset values
  localparam logic [15:0] RST_SETPT = 16'h09C4;
  localparam logic [15:0] RST_PBAND = 16'h07D0;
  localparam logic [15:0] RST_DBAND = 16'h0064;
  localparam logic [15:0] RST_MULT  = 16'h0064;
  // Power in hundredths of a percent
  localparam int    FULL_PWR  = 10000;
  localparam int    P_SPAN    = 2 * FULL_PWR;
  localparam int    MULT_UNIT = 100;
  // Timing
  localparam int    CLK_MHZ        = 50;
  localparam int    SAMPLE_TIME_US = 1000;
  localparam int    SAMPLE_CYC     = SAMPLE_TIME_US * CLK_MHZ;
  localparam int    TICKS_PER_MIN  = 60000000 / SAMPLE_TIME_US;
  localparam int    I_SCALE        = MULT_UNIT * TICKS_PER_MIN;
  localparam int    D_SCALE        = TICKS_PER_MIN / MULT_UNIT;
  localparam longint ACC_LIM       = longint'(FULL_PWR) * longint'(I_SCALE);
  typedef struct packed {
    logic        out_on;
    logic        nv_en;
    pidp_ctype_t ctype;
    logic [15:0] setpt;
    logic [15:0] pband;
    logic [15:0] igain;
    logic [15:0] dgain;
    logic [15:0] dband;
    logic [15:0] ofs1;
    logic [15:0] ofs2;
    logic [15:0] heatm;
    logic [15:0] coolm;
  } pidp_cfg_t;
endpackage

/* File: rtl/pidp_sat.sv */
`timescale 1ns/10ps
`default_nettype none
module pidp_sat #(
  parameter int     WI  = 40,
  parameter int     WO  = 16,
  parameter longint LIM = 10000
) (
  input  wire logic signed [WI-1:0] din,
  output logic signed [WO-1:0]      dout
);
  localparam logic signed [WI-1:0] HI = WI'(LIM);
  localparam logic signed [WI-1:0] LO = -HI;
  always_comb begin
    if (din > HI) begin
      dout = WO'(HI);
    end else if (din < LO) begin
      dout = WO'(LO);
    end else begin
      dout = WO'(din);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pidp_top.sv */
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module pidp_top import pidp_pkg::*; #(
  parameter int TICK_CYC = SAMPLE_CYC
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire logic [7:0]         AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  input  wire logic [3:0]         AVS_BYTEENABLE,
  output logic [31:0]             AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  input  wire logic signed [15:0] TEMP1_IN,
  input  wire logic signed [15:0] TEMP2_IN,
  output logic signed [15:0]      POWER_OUT,
  output logic                    POWER_EN,
  output logic                    NV_WR,
  output logic [7:0]              NV_ADDR,
  output logic [15:0]             NV_DATA
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_P    = 4'b0010,
    S_I    = 4'b0100,
    S_M    = 4'b1000
  } pidp_st_t;
  //////////////////////////////////////////////////////////////////////
  // Register bus
  pidp_cfg_t   cfg_q, cfg_d;
  logic        wrq_q, wrq_d, acc_w;
  logic [31:0] rd_d;
  logic [15:0] wv, nv_data_d;
  logic        nv_wr_d;
  logic signed [15:0] t1_q, t1_d, t2_q, t2_d;
  logic        sat_q, sat_d;
  pidp_st_t    st_q, st_d;

  function automatic logic [15:0] mrg(logic [15:0] o, logic [31:0] w, logic [3:0] be);
    mrg = {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
  endfunction

  function automatic logic [15:0] clampu(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
    clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign acc_w = AVS_WRITE && !wrq_q;

  always_comb begin
    cfg_d     = cfg_q;
    wrq_d     = ~((AVS_READ | AVS_WRITE) & wrq_q);
    rd_d      = AVS_READDATA;
    nv_wr_d   = 1'b0;
    nv_data_d = NV_DATA;
    wv        = 16'h0000;
    // Offsets applied every cycle
    t1_d      = TEMP1_IN + $signed(cfg_q.ofs1);
    t2_d      = TEMP2_IN + $signed(cfg_q.ofs2);
    if (acc_w) begin
      nv_wr_d = cfg_q.nv_en;
      if (AVS_ADDRESS == A_CTRL) begin
        wv = mrg({12'h000, cfg_q.ctype, cfg_q.nv_en, cfg_q.out_on},
                 AVS_WRITEDATA, AVS_BYTEENABLE);
        cfg_d.out_on = wv[CTRL_OUT_ON];
        cfg_d.nv_en  = wv[CTRL_NV_EN];
        cfg_d.ctype  = pidp_ctype_t'(wv[CTRL_TYPE_HI:CTRL_TYPE_LO]);
      end else if (AVS_ADDRESS == A_SETPT) begin
        wv = mrg(cfg_q.setpt, AVS_WRITEDATA, AVS_BYTEENABLE);
        cfg_d.setpt = wv;
      end else if (AVS_ADDRESS == A_PBAND) begin
        wv = clampu(mrg(cfg_q.pband, AVS_WRITEDATA, AVS_BYTEENABLE),
                    PBAND_MIN, PBAND_MAX);
        cfg_d.pband = wv;
      end else if (AVS_ADDRESS == A_IGAIN) begin
        wv = clampu(mrg(cfg_q.igain, AVS_WRITEDATA, AVS_BYTEENABLE),
                    16'h0000, GAIN_MAX);
        cfg_d.igain = wv;
      end else if (AVS_ADDRESS == A_DGAIN) begin
        wv = clampu(mrg(cfg_q.dgain, AVS_WRITEDATA, AVS_BYTEENABLE),
                    16'h0000, GAIN_MAX);
        cfg_d.dgain = wv;
      end else if (AVS_ADDRESS == A_DBAND) begin
        wv = clampu(mrg(cfg_q.dband, AVS_WRITEDATA, AVS_BYTEENABLE),
                    DBAND_MIN, DBAND_MAX);
        cfg_d.dband = wv;
      end else if (AVS_ADDRESS == A_OFS1) begin
        wv = mrg(cfg_q.ofs1, AVS_WRITEDATA, AVS_BYTEENABLE);
        cfg_d.ofs1 = wv;
      end else if (AVS_ADDRESS == A_OFS2) begin
        wv = mrg(cfg_q.ofs2, AVS_WRITEDATA, AVS_BYTEENABLE);
        cfg_d.ofs2 = wv;
      end else if (AVS_ADDRESS == A_HEATM) begin
        wv = clampu(mrg(cfg_q.heatm, AVS_WRITEDATA, AVS_BYTEENABLE),
                    16'h0000, MULT_MAX);
        cfg_d.heatm = wv;
      end else if (AVS_ADDRESS == A_COOLM) begin
        wv = clampu(mrg(cfg_q.coolm, AVS_WRITEDATA, AVS_BYTEENABLE),
                    16'h0000, MULT_MAX);
        cfg_d.coolm = wv;
      end else begin
        nv_wr_d = 1'b0;
      end
      nv_data_d = wv;
    end
    if (AVS_READ && wrq_q) begin
      if (AVS_ADDRESS == A_CTRL) begin
        rd_d = {28'h0000000, cfg_q.ctype, cfg_q.nv_en, cfg_q.out_on};
      end else if (AVS_ADDRESS == A_SETPT) begin
        rd_d = {16'h0000, cfg_q.setpt};
      end else if (AVS_ADDRESS == A_PBAND) begin
        rd_d = {16'h0000, cfg_q.pband};
      end else if (AVS_ADDRESS == A_IGAIN) begin
        rd_d = {16'h0000, cfg_q.igain};
      end else if (AVS_ADDRESS == A_DGAIN) begin
        rd_d = {16'h0000, cfg_q.dgain};
      end else if (AVS_ADDRESS == A_DBAND) begin
        rd_d = {16'h0000, cfg_q.dband};
      end else if (AVS_ADDRESS == A_OFS1) begin
        rd_d = {16'h0000, cfg_q.ofs1};
      end else if (AVS_ADDRESS == A_OFS2) begin
        rd_d = {16'h0000, cfg_q.ofs2};
      end else if (AVS_ADDRESS == A_HEATM) begin
        rd_d = {16'h0000, cfg_q.heatm};
      end else if (AVS_ADDRESS == A_COOLM) begin
        rd_d = {16'h0000, cfg_q.coolm};
      end else if (AVS_ADDRESS == A_TEMP1) begin
        rd_d = {16'h0000, t1_q};
      end else if (AVS_ADDRESS == A_TEMP2) begin
        rd_d = {16'h0000, t2_q};
      end else if (AVS_ADDRESS == A_POWER) begin
        rd_d = {16'h0000, POWER_OUT};
      end else if (AVS_ADDRESS == A_STAT) begin
        rd_d = {28'h0000000, st_q != S_IDLE, sat_q, POWER_EN, 1'b0};
      end else begin
        rd_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_q        <= '{out_on: 1'b0, nv_en: 1'b0, ctype: CT_PID,
                        setpt: RST_SETPT, pband: RST_PBAND,
                        igain: 16'h0000, dgain: 16'h0000,
                        dband: RST_DBAND, ofs1: 16'h0000, ofs2: 16'h0000,
                        heatm: RST_MULT, coolm: RST_MULT};
      wrq_q        <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      NV_WR        <= 1'b0;
      NV_ADDR      <= 8'h00;
      NV_DATA      <= 16'h0000;
      t1_q         <= 16'sh0000;
      t2_q         <= 16'sh0000;
    end else if (CE) begin
      cfg_q        <= cfg_d;
      wrq_q        <= wrq_d;
      AVS_READDATA <= rd_d;
      NV_WR        <= nv_wr_d;
      NV_ADDR      <= nv_wr_d ? AVS_ADDRESS : NV_ADDR;
      NV_DATA      <= nv_data_d;
      t1_q         <= t1_d;
      t2_q         <= t2_d;
    end
  end
  assign AVS_WAITREQUEST = wrq_q;
  //////////////////////////////////////////////////////////////////////
  // Control law, one pass per sample tick
  logic [31:0]        tcnt_q, tcnt_d;
  logic               tick;
  logic signed [16:0] err_q, err_d, err_now, half;
  logic signed [15:0] p_q, p_d, pprev_q, pprev_d, i_q, i_d, d_q, d_d;
  logic signed [15:0] qsat, dsat, ssat, sum_sel, pow_d;
  logic signed [39:0] acc_q, acc_d, acc_sat;
  logic signed [40:0] acc_sum;
  logic signed [47:0] d_raw;
  logic signed [17:0] sum_raw;
  logic signed [39:0] dnum;
  logic [23:0]        dden;
  logic               dstart, dv, en_d;
  logic signed [39:0] dquo;

  assign err_now = $signed({t1_q[15], t1_q}) - $signed({cfg_q.setpt[15], cfg_q.setpt});
  assign tick    = (tcnt_q == 32'h00000000);
  assign half    = $signed({2'b00, cfg_q.dband[15:1]});
  // Integral ramp: proportional output times gain per sample
  assign acc_sum = 41'(acc_q) + 41'(p_d * $signed({1'b0, cfg_q.igain}));
  assign d_raw   = 48'(p_d - pprev_q) * $signed({1'b0, cfg_q.dgain})
                   * 48'(D_SCALE);
  assign sum_raw = 18'(p_q) + 18'(i_d) + 18'(d_q);

  pidp_div #(.WN(40), .WD(24)) u_div (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .start (dstart),
    .num   (dnum),
    .den   (dden),
    .done  (dv),
    .quo   (dquo)
  );
  pidp_sat #(.WI(40), .WO(16), .LIM(FULL_PWR)) u_qsat (
    .din  (dquo),
    .dout (qsat)
  );
  pidp_sat #(.WI(41), .WO(40), .LIM(ACC_LIM)) u_acc (
    .din  (acc_sum),
    .dout (acc_sat)
  );
  pidp_sat #(.WI(48), .WO(16), .LIM(FULL_PWR)) u_dsat (
    .din  (d_raw),
    .dout (dsat)
  );
  pidp_sat #(.WI(18), .WO(16), .LIM(FULL_PWR)) u_sum (
    .din  (sum_raw),
    .dout (ssat)
  );
  always_comb begin
    st_d    = st_q;
    tcnt_d  = tick ? 32'(TICK_CYC - 1) : tcnt_q - 32'h00000001;
    err_d   = err_q;
    p_d     = p_q;
    pprev_d = pprev_q;
    i_d     = i_q;
    d_d     = d_q;
    acc_d   = acc_q;
    pow_d   = POWER_OUT;
    en_d    = cfg_q.out_on;
    sat_d   = sat_q;
    dstart  = 1'b0;
    dnum    = 40'sh0000000000;
    dden    = 24'h000001;
    sum_sel = ssat;
    if (cfg_q.ctype == CT_DBAND) begin
      // Width matters only in this type
      if (err_q > half) begin
        sum_sel = 16'(FULL_PWR);
      end else if (err_q < -half) begin
        sum_sel = -16'(FULL_PWR);
      end else begin
        sum_sel = 16'sh0000;
      end
    end else if (cfg_q.ctype == CT_DIRECT) begin
      sum_sel = $signed(cfg_q.setpt);
    end
    case (st_q)
      S_IDLE: begin
        if (tick) begin
          err_d  = err_now;
          dnum   = 40'(err_now) * 40'(P_SPAN);
          dden   = 24'(cfg_q.pband);
          dstart = 1'b1;
          st_d   = S_P;
        end
      end
      S_P: begin
        p_d = qsat;
        if (dv) begin
          // Accumulator clamped at ACC_LIM, so the integral cannot wind up past full power; it still integrates while the output is saturated
          acc_d   = (cfg_q.ctype == CT_PID) ? acc_sat : 40'sh0000000000;
          d_d     = dsat;
          pprev_d = qsat;
          dnum    = acc_d;
          dden    = 24'(I_SCALE);
          dstart  = 1'b1;
          st_d    = S_I;
        end
      end
      S_I: begin
        if (dv) begin
          i_d    = qsat;
          sat_d  = (sum_raw > 18'(FULL_PWR)) || (sum_raw < -18'(FULL_PWR));
          // Positive demand cools, negative heats
          dnum   = 40'(sum_sel) * 40'(sum_sel < 0 ? cfg_q.heatm : cfg_q.coolm);
          dden   = 24'(MULT_UNIT);
          dstart = 1'b1;
          st_d   = S_M;
        end
      end
      S_M: begin
        if (dv) begin
          pow_d = cfg_q.out_on ? qsat : 16'sh0000;
          st_d  = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q      <= S_IDLE;
      tcnt_q    <= 32'h00000000;
      err_q     <= 17'sh00000;
      p_q       <= 16'sh0000;
      pprev_q   <= 16'sh0000;
      i_q       <= 16'sh0000;
      d_q       <= 16'sh0000;
      acc_q     <= 40'sh0000000000;
      sat_q     <= 1'b0;
      POWER_OUT <= 16'sh0000;
      POWER_EN  <= 1'b0;
    end else if (CE) begin
      st_q      <= st_d;
      tcnt_q    <= tcnt_d;
      err_q     <= err_d;
      p_q       <= p_d;
      pprev_q   <= pprev_d;
      i_q       <= i_d;
      d_q       <= d_d;
      acc_q     <= acc_d;
      sat_q     <= sat_d;
      POWER_OUT <= pow_d;
      POWER_EN  <= en_d;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_pow_range:   assert property (POWER_OUT <= 16'(FULL_PWR) && POWER_OUT >= -16'(FULL_PWR))
    else $error("power out of range");
  a_acc_bound:   assert property (acc_q <= 40'(ACC_LIM) && acc_q >= -40'(ACC_LIM))
    else $error("integral wound up");
  a_igain_range: assert property (cfg_q.igain <= GAIN_MAX)
    else $error("integral gain out of range");
  a_dgain_range: assert property (cfg_q.dgain <= GAIN_MAX)
    else $error("derivative gain out of range");
  a_dband_range: assert property (cfg_q.dband >= DBAND_MIN && cfg_q.dband <= DBAND_MAX)
    else $error("deadband out of range");
  a_pband_range: assert property (cfg_q.pband >= PBAND_MIN && cfg_q.pband <= PBAND_MAX)
    else $error("band out of range");
  a_mult_range:  assert property (cfg_q.heatm <= MULT_MAX && cfg_q.coolm <= MULT_MAX)
    else $error("multiplier out of range");
  a_off_zero:    assert property (CE && st_q == S_M && dv && !cfg_q.out_on |=> POWER_OUT == 0)
    else $error("power while off");
  a_setpt_imm:   assert property (CE && acc_w && AVS_ADDRESS == A_SETPT
                   && AVS_BYTEENABLE == 4'hF |=> cfg_q.setpt == $past(AVS_WRITEDATA[15:0]))
    else $error("set point not taken");
  a_nv_copy:     assert property (CE && acc_w && cfg_q.nv_en && AVS_ADDRESS == A_SETPT
                   |=> NV_WR && NV_ADDR == A_SETPT && NV_DATA == cfg_q.setpt)
    else $error("nonvolatile copy missing");
  a_p_zero:      assert property (CE && st_q == S_P && dv && err_q == 0 |=> p_q == 0)
    else $error("nonzero output at set point");
  a_db_inside:   assert property (CE && st_q == S_I && dv && cfg_q.ctype == CT_DBAND
                   && err_q <= half && err_q >= -half |-> dnum == 0)
    else $error("deadband drives inside band");
  a_ofs1:        assert property (CE |=> t1_q == 16'($past(TEMP1_IN) + $past(cfg_q.ofs1)))
    else $error("primary offset wrong");
  a_ofs2:        assert property (CE |=> t2_q == 16'($past(TEMP2_IN) + $past(cfg_q.ofs2)))
    else $error("secondary offset wrong");
  a_wait_pulse:  assert property (!wrq_q && CE |=> wrq_q)
    else $error("wait low too long");
  c_db_run:  cover property (st_q == S_M && dv && cfg_q.ctype == CT_DBAND);
  c_sat_hit: cover property (sat_q && st_q == S_IDLE);
  c_nv_wr:   cover property (NV_WR);
  c_read:    cover property (AVS_READ && !wrq_q);
endmodule
`default_nettype wire
